// ==== spmc_edge_if.sv ====
/*
 interface carrying synchronised link clock edge pulses between the
 top module and its edge finder.
 assumes all signals are in the clk domain.
*/
`timescale 1ns/1ps
interface spmc_edge_if;
   logic tx_clk_rise;
   logic tx_clk_fall;
   logic rx_clk_fall;
   logic rx_data;
   logic cts;
   logic dsr;
   logic dcd;

   modport finder (output tx_clk_rise, tx_clk_fall, rx_clk_fall, rx_data, cts, dsr, dcd);
   modport user (input tx_clk_rise, tx_clk_fall, rx_clk_fall, rx_data, cts, dsr, dcd);
endinterface : spmc_edge_if

// ==== spmc_modem_model.sv ====
/*
 behavioural far-side modem: handshake replies, gated transmit clock and
 a frame sender for the receive line, async or clocked.
 assumes the bench steers attached, carrier and tx_clk_run.
*/
`timescale 1ns/1ps
module spmc_modem_model
#(
   parameter int BIT_NS = 32
)
(
   input wire logic rts_pin,
   input wire logic dtr_pin,
   output logic cts_pin,
   output logic dsr_pin,
   output logic dcd_pin,
   output logic modem_tx_clock,
   output logic modem_rx_clock,
   output logic rx_data_pin
);
   logic attached = 1'b0;
   logic carrier = 1'b0;
   logic tx_clk_run = 1'b0;

   assign dsr_pin = attached;
   assign dcd_pin = carrier && dtr_pin;
   // clear-to-send trails request, so the port must wait for it
   initial cts_pin = 1'b0;
   always @(rts_pin) cts_pin <= #100 rts_pin;

   // transmit clock stands low while tx_clk_run is off
   initial
   begin
      modem_tx_clock = 1'b0;
      #13;
      forever
      begin
         #40;
         modem_tx_clock = tx_clk_run ? ~modem_tx_clock : 1'b0;
      end
   end

   initial modem_rx_clock = 1'b0;
   initial rx_data_pin = 1'b1;

   task automatic send(input logic [7:0] b, input logic stop, input logic sync);
      logic [10:0] f;
      f = {stop, b, 1'b0, 1'b1};
      for (int i = 0; i < 11; i++)
      begin
         rx_data_pin = f[i];
         if (sync)
         begin
            modem_rx_clock = 1'b1;
            #40;
            modem_rx_clock = 1'b0;
            #40;
         end
         else
            #(BIT_NS);
      end
      rx_data_pin = 1'b1;
   endtask : send
endmodule : spmc_modem_model

// ==== spmc_pin_sync.sv ====
/*
 two-flop synchronisers for every modem-side pin, plus edge detection on the
 two modem clocks, all taken from the second flop.
 assumes pins are asynchronous to clk; clk runs far faster than the link.
*/
`timescale 1ns/1ps
module spmc_pin_sync
(
   input wire logic clk,
   input wire logic rst,
   input wire logic modem_tx_clock,
   input wire logic modem_rx_clock,
   input wire logic rx_data_pin,
   input wire logic cts_pin,
   input wire logic dsr_pin,
   input wire logic dcd_pin,
   spmc_edge_if.finder edges
);

   localparam int N = 6;

   // --------------------------------------------------------------
   // synchronisers
   // --------------------------------------------------------------
   logic [N-1:0] raw;
   logic [N-1:0] meta;
   logic [N-1:0] sync;
   logic [1:0] clk_prev;
   logic [N-1:0] next_meta;
   logic [N-1:0] next_sync;
   logic [1:0] next_clk_prev;

   assign raw = {dcd_pin, dsr_pin, cts_pin, rx_data_pin, modem_rx_clock, modem_tx_clock};

   always_comb
   begin
      next_meta = raw;
      next_sync = meta;
      next_clk_prev = sync[1:0];
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta <= 6'h0c;
         sync <= 6'h0c;
         clk_prev <= 2'h0;
      end
      else
      begin
         meta <= next_meta;
         sync <= next_sync;
         clk_prev <= next_clk_prev;
      end
   end

   // --------------------------------------------------------------
   // edges, seen only from the second flop
   // --------------------------------------------------------------
   assign edges.tx_clk_rise = sync[0] & ~clk_prev[0];
   assign edges.tx_clk_fall = ~sync[0] & clk_prev[0];
   assign edges.rx_clk_fall = ~sync[1] & clk_prev[1];
   assign edges.rx_data = sync[2];
   assign edges.cts = sync[3];
   assign edges.dsr = sync[4];
   assign edges.dcd = sync[5];

endmodule : spmc_pin_sync

// ==== spmc_pkg.sv ====
/*
 package for the terminal-side serial port with modem handshake: framing,
 clocking modes, sampler states and divider defaults.
 assumes a single 250 MHz clock and synchronous active-high reset.
*/
package spmc_pkg;

   // --------------------------------------------------------------
   // clocking and framing
   // --------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int DATA_BITS = 8;
   localparam int BAUD_DIV_DEFAULT = 2170;   // about 115200 baud at 250 MHz
   localparam int LOCAL_CLK_DIV_DEFAULT = 64;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic START_LEVEL = 1'b0;
   localparam logic STOP_LEVEL = 1'b1;

   typedef enum logic [1:0]
   {
      SPMC_CLK_ASYNC,
      SPMC_CLK_SYNC_MODEM,
      SPMC_CLK_SYNC_LOCAL
   } spmc_clk_mode_e;

   typedef enum logic [1:0]
   {
      SPMC_TX_IDLE,
      SPMC_TX_START,
      SPMC_TX_DATA,
      SPMC_TX_STOP
   } spmc_tx_state_e;

   typedef enum logic [1:0]
   {
      SPMC_RX_IDLE,
      SPMC_RX_START,
      SPMC_RX_DATA,
      SPMC_RX_STOP
   } spmc_rx_state_e;

endpackage : spmc_pkg

// ==== spmc_serial_port.sv ====
/*
 terminal-side serial port with modem handshake and optional synchronous
 clocking: an 8N1 transmitter and receiver, handshake gating and the
 terminal clock output.
 assumes a far modem driving the handshake and clock pins, a 250 MHz clk.
*/
// What this block does
// - transmit line idles unless request, clear and carrier are on, except control data.
// - raising request-to-send starts modem transmit; dropping it ends that transmission.
// - while clear-to-send is off, no new user byte is taken; a frame already started still runs to its stop bit.
// - terminal-ready output steers the modem onto the communication channel.
// - with modem transmit clock, transmit bits change on its rising edge.
// - receive data is sampled on the falling edge of the modem receive clock.
// - local terminal clock only in synchronous local mode; otherwise echo modem clock.
// - with local terminal clock, its falling edge sits at each transmit bit centre.
`timescale 1ns/1ps
module spmc_serial_port
#(
   parameter int BAUD_DIV = spmc_pkg::BAUD_DIV_DEFAULT,
   parameter int LOCAL_CLK_DIV = spmc_pkg::LOCAL_CLK_DIV_DEFAULT
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] clk_mode,
   input wire logic terminal_ready_req,
   input wire logic send_request,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_control,
   output logic tx_ready,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_frame_error,
   output logic modem_data_ready,
   output logic modem_control_only,
   input wire logic modem_tx_clock,
   input wire logic modem_rx_clock,
   input wire logic rx_data_pin,
   input wire logic cts_pin,
   input wire logic dsr_pin,
   input wire logic dcd_pin,
   output logic tx_data_pin,
   output logic rts_pin,
   output logic dtr_pin,
   output logic terminal_tx_clock
);

   spmc_edge_if edges();

   spmc_pin_sync u_sync
   (
      .clk(clk),
      .rst(rst),
      .modem_tx_clock(modem_tx_clock),
      .modem_rx_clock(modem_rx_clock),
      .rx_data_pin(rx_data_pin),
      .cts_pin(cts_pin),
      .dsr_pin(dsr_pin),
      .dcd_pin(dcd_pin),
      .edges(edges)
   );

   // --------------------------------------------------------------
   // bit timing
   // --------------------------------------------------------------
   localparam int HALF_LOCAL = (LOCAL_CLK_DIV / 2 < 1) ? 1 : LOCAL_CLK_DIV / 2;
   logic is_async;
   logic is_local;
   logic [15:0] baud_cnt;
   logic [15:0] lclk_cnt;
   logic lclk;
   logic [15:0] next_baud_cnt;
   logic [15:0] next_lclk_cnt;
   logic next_lclk;
   logic baud_tick;
   logic lclk_rise;
   logic lclk_fall;
   logic tx_shift_tick;
   logic rx_sample_tick;

   assign is_async = (clk_mode == 2'(spmc_pkg::SPMC_CLK_ASYNC)) || (clk_mode == 2'h3);
   assign is_local = (clk_mode == 2'(spmc_pkg::SPMC_CLK_SYNC_LOCAL));
   assign baud_tick = (baud_cnt == 16'(BAUD_DIV - 1));
   assign lclk_rise = (lclk_cnt == 16'(HALF_LOCAL - 1)) && !lclk;
   assign lclk_fall = (lclk_cnt == 16'(HALF_LOCAL - 1)) && lclk;

   always_comb
   begin
      next_baud_cnt = baud_tick ? 16'h0000 : baud_cnt + 16'h0001;
      next_lclk_cnt = (lclk_cnt == 16'(HALF_LOCAL - 1)) ? 16'h0000 : lclk_cnt + 16'h0001;
      next_lclk = (lclk_cnt == 16'(HALF_LOCAL - 1)) ? ~lclk : lclk;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         baud_cnt <= 16'h0000;
         lclk_cnt <= 16'h0000;
         lclk <= 1'b1;
      end
      else
      begin
         baud_cnt <= next_baud_cnt;
         lclk_cnt <= next_lclk_cnt;
         lclk <= next_lclk;
      end
   end

   // bits change on rising edges so the falling edge lands mid-bit
   always_comb
   begin
      if (is_async)
      begin
         tx_shift_tick = baud_tick;
         rx_sample_tick = 1'b0;
      end
      else if (is_local)
      begin
         tx_shift_tick = lclk_rise;
         rx_sample_tick = edges.rx_clk_fall;
      end
      else
      begin
         tx_shift_tick = edges.tx_clk_rise;
         rx_sample_tick = edges.rx_clk_fall;
      end
   end

   // --------------------------------------------------------------
   // handshake
   // --------------------------------------------------------------
   logic tx_permit;

   assign rts_pin = send_request;
   assign dtr_pin = terminal_ready_req;
   assign tx_permit = rts_pin & edges.cts & edges.dcd;
   assign modem_data_ready = edges.cts & edges.dsr & rts_pin & dtr_pin;
   assign modem_control_only = edges.cts & ~edges.dsr & ~edges.dcd;

   // --------------------------------------------------------------
   // transmitter
   // --------------------------------------------------------------
   spmc_pkg::spmc_tx_state_e tx_state;
   spmc_pkg::spmc_tx_state_e next_tx_state;
   logic [7:0] tx_shift;
   logic [7:0] next_tx_shift;
   logic [2:0] tx_bit;
   logic [2:0] next_tx_bit;
   logic tx_line;
   logic next_tx_line;
   logic tx_accept;

   // control data may go out without the handshake
   assign tx_accept = tx_valid && (tx_permit || tx_control);
   assign tx_ready = (tx_state == spmc_pkg::SPMC_TX_IDLE) && tx_shift_tick
                     && (tx_permit || tx_control);

   always_comb
   begin
      next_tx_state = tx_state;
      next_tx_shift = tx_shift;
      next_tx_bit = tx_bit;
      next_tx_line = tx_line;
      if (tx_shift_tick)
      begin
         case (tx_state)
            spmc_pkg::SPMC_TX_IDLE:
            begin
               next_tx_line = spmc_pkg::LINE_IDLE;
               if (tx_accept)
               begin
                  next_tx_shift = tx_data;
                  next_tx_line = spmc_pkg::START_LEVEL;
                  next_tx_bit = 3'h0;
                  next_tx_state = spmc_pkg::SPMC_TX_DATA;
               end
            end
            spmc_pkg::SPMC_TX_DATA:
            begin
               next_tx_line = tx_shift[0];
               next_tx_shift = {1'b0, tx_shift[7:1]};
               next_tx_bit = tx_bit + 3'h1;
               if (tx_bit == 3'(spmc_pkg::DATA_BITS - 1))
               begin
                  next_tx_state = spmc_pkg::SPMC_TX_STOP;
               end
            end
            spmc_pkg::SPMC_TX_STOP:
            begin
               next_tx_line = spmc_pkg::STOP_LEVEL;
               next_tx_state = spmc_pkg::SPMC_TX_IDLE;
            end
            default:
            begin
               next_tx_state = spmc_pkg::SPMC_TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tx_state <= spmc_pkg::SPMC_TX_IDLE;
         tx_shift <= 8'h00;
         tx_bit <= 3'h0;
         tx_line <= 1'b1;
      end
      else
      begin
         tx_state <= next_tx_state;
         tx_shift <= next_tx_shift;
         tx_bit <= next_tx_bit;
         tx_line <= next_tx_line;
      end
   end

   assign tx_data_pin = tx_line;

   // echo follows the synchronised modem clock, so it lags by the sync delay
   logic tclk_out;
   logic next_tclk_out;

   // the local copy registers the same next value as lclk, so its rise lands
   // on the very edge where the transmit bit changes
   always_comb
   begin
      next_tclk_out = is_local ? next_lclk : (edges.tx_clk_rise ? 1'b1 :
                      (edges.tx_clk_fall ? 1'b0 : tclk_out));
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tclk_out <= 1'b1;
      end
      else
      begin
         tclk_out <= next_tclk_out;
      end
   end

   assign terminal_tx_clock = tclk_out;

   // --------------------------------------------------------------
   // receiver: asynchronous mode oversamples with the baud divider
   // --------------------------------------------------------------
   spmc_pkg::spmc_rx_state_e rx_state;
   spmc_pkg::spmc_rx_state_e next_rx_state;
   logic [15:0] rx_cnt;
   logic [15:0] next_rx_cnt;
   logic [7:0] rx_shift;
   logic [7:0] next_rx_shift;
   logic [2:0] rx_bit;
   logic [2:0] next_rx_bit;
   logic [7:0] next_rx_data;
   logic next_rx_valid;
   logic next_rx_frame_error;
   logic rx_tick;

   // async: count from start edge, sample at bit centre
   assign rx_tick = is_async ? (rx_cnt == 16'(BAUD_DIV - 1)) : rx_sample_tick;

   always_comb
   begin
      next_rx_state = rx_state;
      next_rx_cnt = (rx_tick || rx_state == spmc_pkg::SPMC_RX_IDLE) ? 16'h0000
                    : rx_cnt + 16'h0001;
      next_rx_shift = rx_shift;
      next_rx_bit = rx_bit;
      next_rx_data = rx_data;
      next_rx_valid = 1'b0;
      next_rx_frame_error = 1'b0;
      case (rx_state)
         spmc_pkg::SPMC_RX_IDLE:
         begin
            if (edges.rx_data == spmc_pkg::START_LEVEL)
            begin
               next_rx_state = spmc_pkg::SPMC_RX_START;
               next_rx_cnt = is_async ? 16'(BAUD_DIV / 2) : 16'h0000;
            end
         end
         spmc_pkg::SPMC_RX_START:
         begin
            if (rx_tick)
            begin
               next_rx_bit = 3'h0;
               next_rx_state = (edges.rx_data == spmc_pkg::START_LEVEL)
                               ? spmc_pkg::SPMC_RX_DATA : spmc_pkg::SPMC_RX_IDLE;
            end
         end
         spmc_pkg::SPMC_RX_DATA:
         begin
            if (rx_tick)
            begin
               next_rx_shift = {edges.rx_data, rx_shift[7:1]};
               next_rx_bit = rx_bit + 3'h1;
               if (rx_bit == 3'(spmc_pkg::DATA_BITS - 1))
               begin
                  next_rx_state = spmc_pkg::SPMC_RX_STOP;
               end
            end
         end
         spmc_pkg::SPMC_RX_STOP:
         begin
            if (rx_tick)
            begin
               next_rx_data = rx_shift;
               next_rx_valid = 1'b1;
               next_rx_frame_error = (edges.rx_data != spmc_pkg::STOP_LEVEL);
               next_rx_state = spmc_pkg::SPMC_RX_IDLE;
            end
         end
         default:
         begin
            next_rx_state = spmc_pkg::SPMC_RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rx_state <= spmc_pkg::SPMC_RX_IDLE;
         rx_cnt <= 16'h0000;
         rx_shift <= 8'h00;
         rx_bit <= 3'h0;
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
         rx_frame_error <= 1'b0;
      end
      else
      begin
         rx_state <= next_rx_state;
         rx_cnt <= next_rx_cnt;
         rx_shift <= next_rx_shift;
         rx_bit <= next_rx_bit;
         rx_data <= next_rx_data;
         rx_valid <= next_rx_valid;
         rx_frame_error <= next_rx_frame_error;
      end
   end

endmodule : spmc_serial_port

// ==== spmc_serial_port_chk.sv ====
/*
 checker for the serial port: handshake gating, framing and clock timing.
 assumes one clk domain and pins that pass a two-flop synchroniser.
*/
`timescale 1ns/1ps
module spmc_chk
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] clk_mode,
   input wire logic terminal_ready_req,
   input wire logic send_request,
   input wire logic tx_valid,
   input wire logic tx_control,
   input wire logic tx_ready,
   input wire logic rx_valid,
   input wire logic rx_frame_error,
   input wire logic modem_data_ready,
   input wire logic modem_control_only,
   input wire logic modem_tx_clock,
   input wire logic cts_pin,
   input wire logic dsr_pin,
   input wire logic dcd_pin,
   input wire logic tx_data_pin,
   input wire logic rts_pin,
   input wire logic dtr_pin,
   input wire logic terminal_tx_clock
);
   // ----------------------------------------------------------
   // warm-up count: synced pins read stale values after reset
   // ----------------------------------------------------------
   logic [1:0] warm;
   logic [1:0] next_warm;
   logic hot;
   always_comb next_warm = (warm == 2'h3) ? warm : warm + 2'h1;
   always_ff @(posedge clk) warm <= rst ? 2'h0 : next_warm;
   assign hot = (warm == 2'h3);

   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);

   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   a_gate_take: assert property (hot && tx_valid && tx_ready && !tx_control
      |-> rts_pin && $past(cts_pin, 2) && $past(dcd_pin, 2)) else $error("user byte taken ungated");
   a_start_bit: assert property (tx_valid && tx_ready
      |=> ##[0:1] tx_data_pin == spmc_pkg::START_LEVEL) else $error("no start bit");
   a_ready_idle: assert property (tx_ready |-> tx_data_pin) else $error("ready off idle");
   a_pins_follow: assert property (rts_pin == send_request && dtr_pin == terminal_ready_req)
      else $error("rts or dtr wrong");
   a_data_ready: assert property (hot |-> modem_data_ready ==
      ($past(cts_pin, 2) && $past(dsr_pin, 2) && rts_pin && dtr_pin)) else $error("data ready");
   a_ctl_only: assert property (hot |-> modem_control_only ==
      ($past(cts_pin, 2) && !$past(dsr_pin, 2) && !$past(dcd_pin, 2))) else $error("control only");
   a_clock_echo: assert property (clk_mode != 2'h2 && $rose(modem_tx_clock)
      |-> ##[1:4] terminal_tx_clock) else $error("modem clock not echoed");
   a_bit_on_rise: assert property (clk_mode == 2'h1 && $changed(tx_data_pin)
      |-> modem_tx_clock) else $error("bit moved off rising clock");
   a_local_mid: assert property (clk_mode == 2'h2 && $changed(tx_data_pin)
      |-> terminal_tx_clock) else $error("bit moved in low half");
   a_rx_pulse: assert property (rx_valid |=> !rx_valid) else $error("rx valid held");
   a_ferr_valid: assert property (rx_frame_error |-> rx_valid) else $error("lone frame error");

   c_ctl_take: cover property (tx_valid && tx_ready && tx_control);
   c_ferr: cover property (rx_frame_error);
   c_local: cover property (clk_mode == 2'h2 && $fell(terminal_tx_clock));
endmodule : spmc_chk

bind spmc_serial_port spmc_chk u_chk (.*);

// ==== spmc_serial_port_test.sv ====
/*
 self-checking bench for the serial port against the modem model.
 assumes BAUD_DIV and LOCAL_CLK_DIV of 8 and a 4 ns clock.
*/
`timescale 1ns/1ps
module spmc_serial_port_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] clk_mode = 2'h0;
   logic terminal_ready_req = 1'b0;
   logic send_request = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic tx_valid = 1'b0;
   logic tx_control = 1'b0;
   logic tx_ready, rx_valid, rx_frame_error, modem_data_ready, modem_control_only;
   logic [7:0] rx_data;
   logic tx_data_pin, rts_pin, dtr_pin, terminal_tx_clock;
   wire logic modem_tx_clock, modem_rx_clock, rx_data_pin, cts_pin, dsr_pin, dcd_pin;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;
   int exp_q[$];
   int seed;

   spmc_serial_port #(.BAUD_DIV(8), .LOCAL_CLK_DIV(8)) uut (.*);
   spmc_modem_model #(.BIT_NS(32)) modem (.*);

   initial forever #2 clk = ~clk;

   // ----------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------
   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic results();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fail_count++;
         results();
      end
   end

   // ----------------------------------------------------------
   // transmit and receive tasks
   // ----------------------------------------------------------
   task automatic wait_bit();
      if (clk_mode == 2'h1)
         @(negedge modem_tx_clock);
      else if (clk_mode == 2'h2)
         @(negedge terminal_tx_clock);
      else
         repeat (8) @(negedge clk);
   endtask : wait_bit

   // one byte offered; a taken byte is read back off the line at bit centres
   task automatic put(input logic ctl, input logic take);
      int n;
      logic [9:0] f;
      n = 0;
      exp_q.push_back($urandom & 255);
      @(negedge clk);
      tx_data = exp_q[0][7:0];
      tx_control = ctl;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      tx_valid = 1'b0;
      check("tx taken", {9'h0, n < 400}, {9'h0, take});
      if (n < 400)
      begin
         n = 0;
         while (tx_data_pin !== 1'b0 && n < 100)
         begin
            @(negedge clk);
            n++;
         end
         if (clk_mode == 2'h0)
            repeat (4) @(negedge clk);
         for (int i = 0; i < 10; i++)
         begin
            if (i > 0 || clk_mode != 2'h0)
               wait_bit();
            f[i] = tx_data_pin;
         end
         check("tx frame", f, {spmc_pkg::STOP_LEVEL, exp_q[0][7:0], spmc_pkg::START_LEVEL});
      end
      else
         check("tx idle", {9'h0, tx_data_pin}, 10'h1);
      void'(exp_q.pop_front());
   endtask : put

   task automatic recv(input logic stop, input logic sync);
      int n;
      logic [7:0] b;
      logic [7:0] got;
      logic ferr;
      n = 0;
      b = 8'($urandom);
      got = 8'h00;
      ferr = 1'b0;
      fork
         modem.send(b, stop, sync);
         begin
            while (rx_valid !== 1'b1 && n < 1000)
            begin
               @(posedge clk);
               #1;
               n++;
            end
            // the error flag stands one cycle only, so take it with the data
            got = rx_data;
            ferr = rx_frame_error;
         end
      join
      check("rx seen", {9'h0, n < 1000}, 10'h1);
      check("rx data", {2'h0, got}, {2'h0, b});
      check("rx frame error", {9'h0, ferr}, {9'h0, !stop});
   endtask : recv

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   initial
   begin
      seed = $urandom(54);
      repeat (5) @(negedge clk);
      rst = 1'b0;
      send_request = 1'b1;
      terminal_ready_req = 1'b1;
      #200;
      @(negedge clk);
      check("control only", {9'h0, modem_control_only}, 10'h1);
      check("data ready", {9'h0, modem_data_ready}, 10'h0);
      put(1'b1, 1'b1);
      put(1'b0, 1'b0);
      modem.attached = 1'b1;
      modem.carrier = 1'b1;
      #200;
      @(negedge clk);
      check("data ready", {9'h0, modem_data_ready}, 10'h1);
      for (int i = 0; i < 3; i++)
         put(1'b0, 1'b1);
      clk_mode = 2'h3;
      for (int i = 0; i < 3; i++)
         recv(1'b1, 1'b0);
      recv(1'b0, 1'b0);
      modem.tx_clk_run = 1'b1;
      @(negedge clk);
      clk_mode = 2'h1;
      put(1'b0, 1'b1);
      recv(1'b1, 1'b1);
      modem.tx_clk_run = 1'b0;
      @(negedge clk);
      clk_mode = 2'h2;
      put(1'b0, 1'b1);
      @(negedge clk);
      clk_mode = 2'h0;
      send_request = 1'b0;
      #300;
      put(1'b0, 1'b0);
      check("rts dtr", {8'h0, rts_pin, dtr_pin}, 10'h1);
      results();
   end
endmodule : spmc_serial_port_test
